// *** csg_pkg.sv ***
// shared constants for the color sensor interrupt source, id and gain registers
package csg_pkg;

  // register offsets on the command-addressed byte port
  localparam logic [7:0] ADDR_IRQ_SRC = 8'h03;
  localparam logic [7:0] ADDR_ID = 8'h04;
  localparam logic [7:0] ADDR_GAIN = 8'h07;

  // field positions
  localparam int IRQ_SEL_LSB = 0;
  localparam int ID_REV_LSB = 0;
  localparam int ID_PART_LSB = 4;
  localparam int PRESCALE_LSB = 0;
  localparam int GAIN_LSB = 4;

  // values after reset
  localparam logic [1:0] IRQ_SEL_RESET = 2'h0;
  localparam logic [1:0] GAIN_RESET = 2'h0;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // channel select codes
  localparam logic [1:0] SEL_GREEN = 2'h0;
  localparam logic [1:0] SEL_RED = 2'h1;
  localparam logic [1:0] SEL_BLUE = 2'h2;
  localparam logic [1:0] SEL_CLEAR = 2'h3;

  // analog gain codes
  localparam logic [1:0] GAIN_X1 = 2'h0;
  localparam logic [1:0] GAIN_X4 = 2'h1;
  localparam logic [1:0] GAIN_X16 = 2'h2;
  localparam logic [1:0] GAIN_X64 = 2'h3;

  // prescaler: codes 0..6 shift by the code; 7 is unused and behaves as 6
  localparam logic [2:0] PRESCALE_MAX = 3'h6;
  localparam int PRESCALE_BITS = 6;

  // channel result
  localparam int RESULT_W = 16;
  localparam logic [15:0] FULL_SCALE = 16'hFFFF;

  // read data latency in cycles from the read strobe
  localparam int READ_LATENCY = 1;

endpackage

// *** csg_chan_path.sv ***
// one channel count path: prescaler right shift followed by full-scale saturation
`timescale 1ns/100ps
module csg_chan_path #(
  parameter int RAW_W = csg_pkg::RESULT_W + csg_pkg::PRESCALE_BITS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [RAW_W-1:0] raw_in,
  input wire logic [2:0] shift_in,
  output logic [csg_pkg::RESULT_W-1:0] result_out
);

  typedef struct packed {
    logic [csg_pkg::RESULT_W-1:0] result;
  } csg_path_state_type;

  csg_path_state_type state;
  csg_path_state_type next_state;
  logic [2:0] eff_shift;
  logic [RAW_W-1:0] shifted;

  if (RAW_W < csg_pkg::RESULT_W + csg_pkg::PRESCALE_BITS)
  begin : g_raw_w_check
    $error("csg_chan_path: RAW_W too narrow for the six-bit prescaler");
  end

  always_comb
  begin
    next_state = state;
    // unused code 7 is clamped so the divide never exceeds 64
    eff_shift = (shift_in > csg_pkg::PRESCALE_MAX) ? csg_pkg::PRESCALE_MAX : shift_in;
    // plain shift, low bits are dropped with no rounding
    shifted = raw_in >> eff_shift;
    if (load_in)
    begin
      if (shifted > RAW_W'(csg_pkg::FULL_SCALE))
      begin
        next_state.result = csg_pkg::FULL_SCALE;
      end
      else
      begin
        next_state.result = shifted[csg_pkg::RESULT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign result_out = state.result;

  AST_PATH_SATURATE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    load_in && ((raw_in >> eff_shift) > RAW_W'(csg_pkg::FULL_SCALE)) |=> result_out == csg_pkg::FULL_SCALE)
    else $error("overflowed count did not saturate at full scale");

  AST_PATH_SHIFT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    load_in && ((raw_in >> eff_shift) <= RAW_W'(csg_pkg::FULL_SCALE))
    |=> RAW_W'(result_out) == $past(raw_in >> eff_shift))
    else $error("result is not the truncated right shift of the count");

endmodule

// *** csg_regs.sv ***
// interrupt source, identification and gain registers with the channel count paths
// Summary of operation
// - interrupt source bits 1:0 pick green, red, blue or clear for the comparator.
// - exactly one channel ever feeds the threshold comparison, never a mix.
// - identification register is read-only and constant; writes change nothing.
// - identification byte holds part number in 7:4 and revision in 3:0.
// - gain bits 5:4 set one analog gain for all channels: 1x,4x,16x,64x.
// - prescaler bits 2:0 divide counts by two to the code, 0 to 6.
// - the division is a right shift that drops low bits, no rounding.
// - a six-bit prescaler sits in every channel count path.
// - each result is 16 bits and saturates at full scale instead of wrapping.
// - interrupt asserts when selected value is at or below low or above high.
`timescale 1ns/100ps
module csg_regs #(
  parameter int RAW_W = csg_pkg::RESULT_W + csg_pkg::PRESCALE_BITS,
  // arbitrary identification values
  parameter logic [3:0] PART_NUMBER = 4'hA,
  parameter logic [3:0] REVISION = 4'h3
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic CH_LOAD_IN,
  input wire logic [RAW_W-1:0] GREEN_RAW_IN,
  input wire logic [RAW_W-1:0] RED_RAW_IN,
  input wire logic [RAW_W-1:0] BLUE_RAW_IN,
  input wire logic [RAW_W-1:0] CLEAR_RAW_IN,
  input wire logic [15:0] LOW_THRESH_IN,
  input wire logic [15:0] HIGH_THRESH_IN,
  output logic [7:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  output logic [1:0] GAIN_SEL_OUT,
  output logic [15:0] GREEN_DATA_OUT,
  output logic [15:0] RED_DATA_OUT,
  output logic [15:0] BLUE_DATA_OUT,
  output logic [15:0] CLEAR_DATA_OUT,
  output logic INT_OUT
);

  typedef struct packed {
    logic [1:0] irq_sel;
    logic [1:0] gain;
    logic [2:0] prescale;
    logic [1:0] gain_drive;
    logic [7:0] rdata;
    logic rvalid;
    logic int_flag;
  } csg_regs_state_type;

  csg_regs_state_type state;
  csg_regs_state_type next_state;
  logic rst_meta;
  logic rst_n;
  logic [7:0] read_mux;
  logic [15:0] sel_value;
  logic [15:0] result [4];
  logic [RAW_W-1:0] raw [4];
  logic [7:0] id_byte;

  if (RAW_W < csg_pkg::RESULT_W + csg_pkg::PRESCALE_BITS)
  begin : g_raw_w_check
    $error("csg_regs: RAW_W too narrow for the six-bit prescaler");
  end

  // reset is asserted at once but released through two flops
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  assign raw[0] = GREEN_RAW_IN;
  assign raw[1] = RED_RAW_IN;
  assign raw[2] = BLUE_RAW_IN;
  assign raw[3] = CLEAR_RAW_IN;

  // same prescaler setting drives every channel path
  for (genvar i = 0; i < 4; i++)
  begin : g_path
    csg_chan_path #(
      .RAW_W(RAW_W)
    ) u_path (
      .clk_in(SYS_CLK_IN),
      .rst_n_in(rst_n),
      .load_in(CH_LOAD_IN),
      .raw_in(raw[i]),
      .shift_in(state.prescale),
      .result_out(result[i])
    );
  end

  assign id_byte = {PART_NUMBER, REVISION};

  always_comb
  begin
    // a plain mux, so only one channel can ever reach the comparator
    case (state.irq_sel)
      csg_pkg::SEL_GREEN: sel_value = result[0];
      csg_pkg::SEL_RED: sel_value = result[1];
      csg_pkg::SEL_BLUE: sel_value = result[2];
      csg_pkg::SEL_CLEAR: sel_value = result[3];
      default: sel_value = result[0];
    endcase
  end

  always_comb
  begin
    case (REG_ADDR_IN)
      csg_pkg::ADDR_IRQ_SRC: read_mux = {6'h00, state.irq_sel};
      csg_pkg::ADDR_ID: read_mux = id_byte;
      csg_pkg::ADDR_GAIN: read_mux = {2'h0, state.gain, 1'b0, state.prescale};
      default: read_mux = 8'h00;
    endcase
  end

  always_comb
  begin
    next_state = state;
    next_state.rvalid = REG_RD_IN;
    if (REG_RD_IN)
    begin
      next_state.rdata = read_mux;
    end
    // writes to the identification address or reserved bits are dropped
    if (REG_WR_IN)
    begin
      case (REG_ADDR_IN)
        csg_pkg::ADDR_IRQ_SRC:
        begin
          next_state.irq_sel = REG_WDATA_IN[csg_pkg::IRQ_SEL_LSB +: 2];
        end
        csg_pkg::ADDR_GAIN:
        begin
          next_state.gain = REG_WDATA_IN[csg_pkg::GAIN_LSB +: 2];
          next_state.prescale = REG_WDATA_IN[csg_pkg::PRESCALE_LSB +: 3];
        end
        default:
        begin
          next_state.irq_sel = state.irq_sel;
        end
      endcase
    end
    // one common code goes to all four analog front ends
    next_state.gain_drive = state.gain;
    // level flag tracks the selected channel against both thresholds
    next_state.int_flag = (sel_value <= LOW_THRESH_IN) || (sel_value > HIGH_THRESH_IN);
  end

  always_ff @(posedge SYS_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state.irq_sel <= csg_pkg::IRQ_SEL_RESET;
      state.gain <= csg_pkg::GAIN_RESET;
      state.prescale <= csg_pkg::PRESCALE_RESET;
      state.gain_drive <= csg_pkg::GAIN_RESET;
      state.rdata <= csg_pkg::RDATA_RESET;
      state.rvalid <= 1'b0;
      state.int_flag <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign REG_RDATA_OUT = state.rdata;
  assign REG_RVALID_OUT = state.rvalid;
  assign GAIN_SEL_OUT = state.gain_drive;
  assign GREEN_DATA_OUT = result[0];
  assign RED_DATA_OUT = result[1];
  assign BLUE_DATA_OUT = result[2];
  assign CLEAR_DATA_OUT = result[3];
  assign INT_OUT = state.int_flag;

  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!rst_n);

  AST_SEL_ROUTE: assert property (
    sel_value == result[state.irq_sel])
    else $error("comparator value is not the selected channel");

  AST_SINGLE_SOURCE: assert property (
    $past(rst_n) && $stable(result[state.irq_sel]) && $stable(state.irq_sel) && $stable(LOW_THRESH_IN)
    && $stable(HIGH_THRESH_IN) |=> $stable(INT_OUT))
    else $error("interrupt changed though the selected channel did not");

  AST_ID_READ: assert property (
    REG_RD_IN && REG_ADDR_IN == csg_pkg::ADDR_ID |=> REG_RVALID_OUT && REG_RDATA_OUT == id_byte)
    else $error("identification read did not return the constant");

  AST_ID_FIELDS: assert property (
    REG_RVALID_OUT && $past(REG_ADDR_IN) == csg_pkg::ADDR_ID
    |-> REG_RDATA_OUT[7:4] == PART_NUMBER && REG_RDATA_OUT[3:0] == REVISION)
    else $error("identification fields misplaced");

  AST_GAIN_DRIVE: assert property (
    REG_WR_IN && REG_ADDR_IN == csg_pkg::ADDR_GAIN
    |=> ##1 GAIN_SEL_OUT == $past(REG_WDATA_IN[5:4], 2))
    else $error("analog gain code not driven two cycles after the write");

  AST_PRESCALE_WRITE: assert property (
    REG_WR_IN && REG_ADDR_IN == csg_pkg::ADDR_GAIN |=> state.prescale == $past(REG_WDATA_IN[2:0]))
    else $error("prescaler field not stored");

  AST_IRQ_LEVEL: assert property (
    rst_n |=> INT_OUT ==
    (($past(sel_value) <= $past(LOW_THRESH_IN)) || ($past(sel_value) > $past(HIGH_THRESH_IN))))
    else $error("interrupt level disagrees with the threshold comparison");

  AST_RESV_ZERO: assert property (
    REG_RD_IN && (REG_ADDR_IN == csg_pkg::ADDR_IRQ_SRC || REG_ADDR_IN == csg_pkg::ADDR_GAIN)
    |=> (REG_RDATA_OUT & (($past(REG_ADDR_IN) == csg_pkg::ADDR_GAIN) ? 8'hC8 : 8'hFC)) == 8'h00)
    else $error("reserved bits read as nonzero");

  AST_READ_PULSE: assert property (
    REG_RD_IN |=> REG_RVALID_OUT ##1 (REG_RVALID_OUT == $past(REG_RD_IN)))
    else $error("read answer not a one-cycle strobe per request");

  AST_IRQ_SEL_WRITE: assert property (
    REG_WR_IN && REG_ADDR_IN == csg_pkg::ADDR_IRQ_SRC
    |=> state.irq_sel == $past(REG_WDATA_IN[1:0]))
    else $error("interrupt source select not stored");

  AST_GAIN_WRITE: assert property (
    REG_WR_IN && REG_ADDR_IN == csg_pkg::ADDR_GAIN
    |=> state.gain == $past(REG_WDATA_IN[5:4]))
    else $error("analog gain field not stored");

  AST_ID_WRITE_IGNORED: assert property (
    REG_WR_IN && REG_ADDR_IN == csg_pkg::ADDR_ID
    |=> $stable(state.irq_sel) && $stable(state.gain) && $stable(state.prescale))
    else $error("write to the identification address changed a register");

  AST_GAIN_COMMON: assert property (
    rst_n
    |=> GAIN_SEL_OUT == $past(state.gain))
    else $error("analog gain code does not follow the gain field");

  AST_RVALID_IDLE: assert property (
    !REG_RD_IN
    |=> !REG_RVALID_OUT)
    else $error("read answer without a read request");

  AST_RDATA_HOLD: assert property (
    !REG_RD_IN
    |=> $stable(REG_RDATA_OUT))
    else $error("read data changed without a read request");

  AST_UNMAPPED_READ: assert property (
    REG_RD_IN && REG_ADDR_IN != csg_pkg::ADDR_IRQ_SRC && REG_ADDR_IN != csg_pkg::ADDR_ID
    && REG_ADDR_IN != csg_pkg::ADDR_GAIN |=> REG_RDATA_OUT == 8'h00)
    else $error("unmapped address did not read as zero");

  AST_IRQ_READBACK: assert property (
    REG_RD_IN && REG_ADDR_IN == csg_pkg::ADDR_IRQ_SRC
    |=> REG_RDATA_OUT == {6'h00, $past(state.irq_sel)})
    else $error("interrupt source read back wrong");

  AST_GAIN_READBACK: assert property (
    REG_RD_IN && REG_ADDR_IN == csg_pkg::ADDR_GAIN
    |=> REG_RDATA_OUT == {2'h0, $past(state.gain), 1'b0, $past(state.prescale)})
    else $error("gain register read back wrong");

  AST_NO_WRITE_KEEP: assert property (
    !REG_WR_IN
    |=> $stable(state.irq_sel) && $stable(state.gain) && $stable(state.prescale))
    else $error("register changed without a write");

  AST_IRQ_ABOVE: assert property (
    rst_n && sel_value > HIGH_THRESH_IN
    |=> INT_OUT)
    else $error("no interrupt above the upper threshold");

  AST_IRQ_BELOW: assert property (
    rst_n && sel_value <= LOW_THRESH_IN
    |=> INT_OUT)
    else $error("no interrupt at or below the lower threshold");

  AST_IRQ_INSIDE: assert property (
    rst_n && sel_value > LOW_THRESH_IN && sel_value <= HIGH_THRESH_IN
    |=> !INT_OUT)
    else $error("interrupt raised inside the threshold window");

  AST_DATA_HOLD: assert property (
    !CH_LOAD_IN
    |=> $stable(GREEN_DATA_OUT) && $stable(RED_DATA_OUT) && $stable(BLUE_DATA_OUT) && $stable(CLEAR_DATA_OUT))
    else $error("channel result changed without a load");

endmodule

// *** csg_host.sv ***
// host processor model on the register byte port, plus the threshold levels it programs
`timescale 1ns/100ps
module csg_host (
  input wire logic clk_in,
  input wire logic rvalid_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out,
  output logic [15:0] low_out,
  output logic [15:0] high_out
);
  initial
  begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
    low_out = 16'h0000;
    high_out = 16'hFFFF;
  end
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    // data is no longer qualified, so do not leave it looking valid
    wdata_out <= ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1;
    v = rvalid_in;
    d = rdata_in;
  endtask
  // one low and high threshold pair, compared against whichever channel is picked as interrupt source
  task automatic set_thresh(input logic [15:0] lo, input logic [15:0] hi);
    @(posedge clk_in);
    low_out <= lo;
    high_out <= hi;
  endtask
endmodule

// *** tb.sv ***
// self-checking bench for the interrupt source, identification and gain registers
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst_n;
  logic load;
  logic [21:0] raw [4];
  logic [15:0] dout [4];
  logic [7:0] addr, wdata, rdata, rb;
  logic wr, rd, rvalid, rv, irq;
  logic [15:0] lo, hi;
  logic [1:0] gsel;
  int fails = 0;
  int comparisons = 0;
  always #25 clk = ~clk;
  csg_host host (.clk_in(clk), .rvalid_in(rvalid), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
    .rd_out(rd), .wdata_out(wdata), .low_out(lo), .high_out(hi));
  // identification values are arbitrary
  csg_regs #(.PART_NUMBER(4'h5), .REVISION(4'h2)) dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
    .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wdata), .CH_LOAD_IN(load),
    .GREEN_RAW_IN(raw[0]), .RED_RAW_IN(raw[1]), .BLUE_RAW_IN(raw[2]), .CLEAR_RAW_IN(raw[3]),
    .LOW_THRESH_IN(lo), .HIGH_THRESH_IN(hi), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
    .GAIN_SEL_OUT(gsel), .GREEN_DATA_OUT(dout[0]), .RED_DATA_OUT(dout[1]), .BLUE_DATA_OUT(dout[2]),
    .CLEAR_DATA_OUT(dout[3]), .INT_OUT(irq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // code 7 is unused and taken as the deepest shift
  function automatic logic [15:0] scaled(input logic [21:0] r, input logic [2:0] p);
    logic [21:0] v;
    v = r >> ((p > 3'h6) ? 3'h6 : p);
    return (v > 22'h00FFFF) ? 16'hFFFF : v[15:0];
  endfunction
  task automatic load_all(input logic [21:0] g, input logic [21:0] r, input logic [21:0] b,
    input logic [21:0] c);
    @(posedge clk);
    load <= 1'b1;
    raw[0] <= g;
    raw[1] <= r;
    raw[2] <= b;
    raw[3] <= c;
    @(posedge clk);
    load <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    host.read_reg(a, rb, rv);
    check({31'h0, rv}, 32'h1);
    check({24'h0, rb}, {24'h0, exp});
  endtask
  task automatic thr_check(input logic [15:0] l, input logic [15:0] h, input logic exp);
    host.set_thresh(l, h);
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, irq}, {31'h0, exp});
  endtask
  initial
  begin
    #200000;
    fails++;
    results();
  end
  initial
  begin
    rst_n = 1'b0;
    load = 1'b0;
    for (int k = 0; k < 4; k++)
      raw[k] = 22'h000000;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_check(8'h03, 8'h00);
    rd_check(8'h07, 8'h00);
    rd_check(8'h04, 8'h52);
    host.write_reg(8'h04, 8'hFF);
    rd_check(8'h04, 8'h52);
    rd_check(8'h20, 8'h00);
    host.write_reg(8'h07, 8'hFF);
    rd_check(8'h07, 8'h37);
    host.write_reg(8'h03, 8'hFF);
    rd_check(8'h03, 8'h03);
    for (int p = 0; p < 8; p++)
    begin
      host.write_reg(8'h07, {2'h0, p[1:0], 1'b0, p[2:0]});
      rd_check(8'h07, {2'h0, p[1:0], 1'b0, p[2:0]});
      load_all(22'h3FFFFF, 22'h012345, 22'h00ABCD, 22'h000001);
      check({30'h0, gsel}, {30'h0, p[1:0]});
      for (int k = 0; k < 4; k++)
        check({16'h0, dout[k]}, {16'h0, scaled(raw[k], p[2:0])});
    end
    host.write_reg(8'h07, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      host.write_reg(8'h03, {6'h00, s[1:0]});
      load_all((s == 0) ? 22'd100 : 22'd5, (s == 1) ? 22'd100 : 22'd5, (s == 2) ? 22'd100 : 22'd5,
        (s == 3) ? 22'd100 : 22'd5);
      thr_check(16'd50, 16'd200, 1'b0);
      thr_check(16'd50, 16'd99, 1'b1);
      thr_check(16'd50, 16'd100, 1'b0);
      thr_check(16'd100, 16'd200, 1'b1);
    end
    // a second reset in mid-run must bring back the reset values
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_check(8'h03, 8'h00);
    check({16'h0, dout[3]}, 32'h0);
    check({31'h0, irq}, 32'h1);
    results();
  end
endmodule
